/* File: logic/pwcd_defs.svh */
/*
 Timing and count constants of the pulse width command decoder.
 Assumes a 50 MHz system clock and a 1 ms internal timebase.
*/
`ifndef PWCD_DEFS_SVH
`define PWCD_DEFS_SVH

// Clock and timebase
`define PWCD_CLK_HZ        50000000
`define PWCD_CLK_NS        (1000000000 / `PWCD_CLK_HZ)
`define PWCD_TICK_NS       1000000
`define PWCD_TICK_CYC      (`PWCD_TICK_NS / `PWCD_CLK_NS)
`define PWCD_TICK_MS       1

// Command widths, tolerance and overlength limit in ms
`define PWCD_CMD_ONE_MS    2000
`define PWCD_CMD_FILL_MS   12000
`define PWCD_CMD_ACK_MS    14000
`define PWCD_TOL_MS        100
`define PWCD_DASH_MS       15000

// Status timing in ms
`define PWCD_READY_MS      3000
`define PWCD_GAP_MS        500
`define PWCD_SQ_HALF_MS    1000

// Same figures in timebase ticks
`define PWCD_ONE_LO        ((`PWCD_CMD_ONE_MS - `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_ONE_HI        ((`PWCD_CMD_ONE_MS + `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_FILL_LO       ((`PWCD_CMD_FILL_MS - `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_FILL_HI       ((`PWCD_CMD_FILL_MS + `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_ACK_LO        ((`PWCD_CMD_ACK_MS - `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_ACK_HI        ((`PWCD_CMD_ACK_MS + `PWCD_TOL_MS) / `PWCD_TICK_MS)
`define PWCD_DASH_CNT      (`PWCD_DASH_MS / `PWCD_TICK_MS)
`define PWCD_READY_CNT     (`PWCD_READY_MS / `PWCD_TICK_MS)
`define PWCD_GAP_CNT       (`PWCD_GAP_MS / `PWCD_TICK_MS)
`define PWCD_SQ_CNT        (`PWCD_SQ_HALF_MS / `PWCD_TICK_MS)

// Fill sequence and pressure display range
`define PWCD_FILL_RUNS     40
`define PWCD_PRESS_MIN     1
`define PWCD_PRESS_MAX     50

`endif

/* File: logic/pwcd_pkg.sv */
/*
 Types of the pulse width command decoder.
 Assumes pwcd_defs.svh for all figures.
*/
package pwcd_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_CHECK = 3'h0,
      ST_IDLE  = 3'h1,
      ST_RUN   = 3'h2,
      ST_GAP   = 3'h3,
      ST_ERROR = 3'h4,
      ST_ACK   = 3'h5
   } pwcd_state_t;

   // Fault levels from the monitoring logic
   typedef struct packed {
      logic cart_empty;
      logic cart_missing;
      logic overload_fault;
      logic undervoltage_fault;
      logic fatal_fault;
   } pwcd_fault_t;

   // Display and LED indications
   typedef struct packed {
      logic       green;
      logic       red;
      logic       mode_flash;
      logic       dash;
      logic [5:0] pressure;
   } pwcd_ind_t;

endpackage

/* File: logic/pwcd_top.sv */
/*
 Pulse width command decoder for pulse_control_mode: measures command
 pulses on the line from the controller, sequences motor runs and drives
 the one-wire status line back.
 Assumes: cmd_pin_i is asynchronous; all other inputs come from logic on
 clk_i; the motor logic pulses motor_done_i when a motor_run ends.
*/
// Notes on behaviour
// R1: Pulse width picks function: 2 s one stroke, 12 s fill, 14 s acknowledge.
// R2: Accepted widths lie within plus or minus 0.1 s of nominal.
// R3: Widths outside every window are ignored with no action.
// R4: Input high beyond 15 s shows a dash and does nothing.
// R5: Status stays high when ready; controller waits over 3 s of high.
// R6: Mode indication flashes while the command input is high.
// R7: Motor run starts on the falling edge of a valid command.
// R8: Status is low for the whole motor run.
// R9: Motor run lasts 7 to 17 s; its end comes from the motor.
// R10: Error-free run end returns status from low to high.
// R11: Fill does 40 runs with 0.5 s high gaps between them.
// R12: Commands ignored until over 3 s after the last good run end.
// R13: Controller leaves at least 22 s between command pulses.
// R14: Green LED lit and back pressure 1 to 50 shown during a run.
// R15: Faults during or right after a run give status pattern, red flash.
// R16: After power-up, self check runs, then wait for a command.
// R17: Empty cartridge gives 0.5 Hz square wave; other faults hold low.
// R18: In low error only acknowledge counts; passing check clears faults (code clears overload and undervoltage only; fatal stays latched).
// R19: Width is counted in timebase ticks between synchronised edges.
`timescale 1ns/10ps
`include "pwcd_defs.svh"

module pwcd_top #(
   parameter int TICK_CYC = `PWCD_TICK_CYC
) (
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               cmd_pin_i,
   input  wire logic               motor_done_i,
   input  wire logic [5:0]         pressure_i,
   input  wire pwcd_pkg::pwcd_fault_t fault_i,
   input  wire logic               check_done_i,
   input  wire logic               check_pass_i,
   output logic                    status_o,
   output logic                    motor_run_o,
   output logic                    check_req_o,
   output pwcd_pkg::pwcd_ind_t     ind_o
);
   import pwcd_pkg::*;

   // Whole state of the block
   typedef struct packed {
      pwcd_state_t st;
      logic [2:0]  sync;
      logic        cmd;
      logic        taken;
      logic [15:0] div;
      logic [13:0] width;
      logic [13:0] tmr;
      logic [5:0]  runs;
      logic        empty;
      logic        ovl;
      logic        uvl;
      logic        fatal;
      logic        status;
      logic        motor;
      logic        chk;
      pwcd_ind_t   ind;
   } pwcd_regs_t;

   pwcd_regs_t q;
   pwcd_regs_t d;
   logic       tick;
   logic       rise;
   logic       fall;
   logic       is_one;
   logic       is_fill;
   logic       is_ack;
   logic       err_low;
   logic       err_any;

   // Timing notes for the next engineer:
   // - All command and status timing is in timebase ticks, so the block
   //   scales with TICK_CYC; a short TICK_CYC keeps simulations fast.
   // - Width is quantised to one tick; the acceptance windows are
   //   therefore accurate to about one tick at each end.
   // - The synchroniser adds three to four clocks before any edge is seen,
   //   which is far below one tick and does not disturb the windows.
   // - The pause between command pulses is the controller's duty; it is
   //   not policed here, only the ready window after a run is.
   // - Motor run length is not timed here: the motor logic ends each run,
   //   so any length the mechanics need is accepted.
   // - Faults are levels from the monitoring logic; overload, undervoltage
   //   and fatal are latched so a short glitch still stops the motor.
   // - Cartridge empty is only looked at when a run ends, since the stroke
   //   counter behind it changes only then.

   // Next state of every flop
   always_comb begin
      d = q;
      // 1 ms enable from the divider
      tick = (q.div == 16'(TICK_CYC - 1));
      d.div = tick ? 16'h0000 : q.div + 16'h0001;

      // Three-stage synchroniser, stage 1 feeds only stage 2
      d.sync = {q.sync[1:0], cmd_pin_i};
      if (q.sync[1] == q.sync[2]) begin
         d.cmd = q.sync[2];
      end
      rise = d.cmd & ~q.cmd;
      fall = ~d.cmd & q.cmd;

      // Width counter saturates just past the overlength limit
      if (rise) begin
         d.width = 14'h0000; // see R19
      end else if (q.cmd && tick && q.width <= 14'(`PWCD_DASH_CNT)) begin
         d.width = q.width + 14'h0001; // see R19
      end
      d.ind.dash = d.cmd & (d.width > 14'(`PWCD_DASH_CNT)); // see R4
      d.ind.mode_flash = d.cmd & d.width[8]; // see R6

      // Windows on the measured width; anything else matches nothing
      is_one  = q.width >= 14'(`PWCD_ONE_LO) && q.width <= 14'(`PWCD_ONE_HI); // see R1 R2
      is_fill = q.width >= 14'(`PWCD_FILL_LO) && q.width <= 14'(`PWCD_FILL_HI); // see R1 R2
      is_ack  = q.width >= 14'(`PWCD_ACK_LO) && q.width <= 14'(`PWCD_ACK_HI); // see R1 R2

      // Latched faults; a new fault wins over an acknowledge clear
      d.ovl   = q.ovl | fault_i.overload_fault;
      d.uvl   = q.uvl | fault_i.undervoltage_fault;
      d.fatal = q.fatal | fault_i.fatal_fault;
      if (fault_i.cart_missing) begin
         d.empty = 1'b0; // Removal ends the empty report
      end
      err_low = fault_i.cart_missing | q.ovl | q.uvl | q.fatal;
      err_any = err_low | q.empty;

      case (q.st)
         // Power-up self check, then wait with no dispense
         ST_CHECK: begin
            d.status = 1'b0;
            d.chk = 1'b1; // see R16
            if (check_done_i) begin
               d.chk = 1'b0;
               d.tmr = 14'h0000;
               if (check_pass_i) begin
                  d.st = ST_IDLE; // see R16
                  d.status = 1'b1;
               end else begin
                  d.fatal = 1'b1;
                  d.st = ST_ERROR;
               end
            end
         end

         // Ready: status high, count the high time before arming
         ST_IDLE: begin
            d.status = 1'b1; // see R5
            d.ind.red = 1'b0;
            if (tick && q.tmr <= 14'(`PWCD_READY_CNT)) begin
               d.tmr = q.tmr + 14'h0001;
            end
            // Only a pulse that starts after more than 3 s is heard
            if (rise) begin
               d.taken = q.tmr > 14'(`PWCD_READY_CNT); // see R5 R12
            end
            if (err_any) begin
               d.st = ST_ERROR;
               d.status = 1'b0;
               d.tmr = 14'h0000;
            end else if (fall && q.taken && (is_one || is_fill)) begin
               d.runs = is_one ? 6'h01 : 6'(`PWCD_FILL_RUNS); // see R11
               d.st = ST_RUN; // see R7
               d.motor = 1'b1;
               d.status = 1'b0; // see R8
               d.ind.green = 1'b1; // see R14
               d.taken = 1'b0;
            end else if (fall) begin
               d.taken = 1'b0; // see R3 R4
            end
         end

         // Motor turning; the motor logic decides the 7 to 17 s length
         ST_RUN: begin
            d.status = 1'b0; // see R8
            if (pressure_i < 6'(`PWCD_PRESS_MIN)) begin
               d.ind.pressure = 6'(`PWCD_PRESS_MIN); // see R14
            end else if (pressure_i > 6'(`PWCD_PRESS_MAX)) begin
               d.ind.pressure = 6'(`PWCD_PRESS_MAX); // see R14
            end else begin
               d.ind.pressure = pressure_i; // see R14
            end
            if (err_low) begin
               // A fault stops the run at once; remaining runs are kept
               d.motor = 1'b0;
               d.ind.green = 1'b0;
               d.st = ST_ERROR; // see R15
               d.tmr = 14'h0000;
            end else if (motor_done_i) begin // see R9
               d.motor = 1'b0;
               d.ind.green = 1'b0;
               d.runs = q.runs - 6'h01;
               d.tmr = 14'h0000;
               if (fault_i.cart_empty) begin
                  d.empty = 1'b1; // see R15
               end
               if (fault_i.cart_empty || fault_i.overload_fault
                   || fault_i.undervoltage_fault || fault_i.fatal_fault) begin
                  d.st = ST_ERROR; // see R15
               end else if (q.runs == 6'h01) begin
                  d.st = ST_IDLE;
                  d.status = 1'b1; // see R10
               end else begin
                  d.st = ST_GAP;
                  d.status = 1'b1; // see R11
               end
            end
         end

         // High gap between fill runs
         ST_GAP: begin
            d.status = 1'b1; // see R11
            if (tick) begin
               d.tmr = q.tmr + 14'h0001;
            end
            if (err_any) begin
               d.st = ST_ERROR;
               d.status = 1'b0;
               d.tmr = 14'h0000;
            end else if (tick && q.tmr == 14'(`PWCD_GAP_CNT - 1)) begin
               d.st = ST_RUN; // see R11
               d.motor = 1'b1;
               d.status = 1'b0;
               d.ind.green = 1'b1;
            end
         end

         // Error pattern on the status line, red flashing.
         // Low faults hold the line low; only an empty cartridge lets the
         // square wave through, so the controller can tell the two apart.
         // A pulse rising here is always taken: the ready window does not
         // apply, because the line is not held steadily high while a fault stands.
         ST_ERROR: begin
            if (tick) begin
               d.tmr = q.tmr + 14'h0001;
            end
            if (tick && q.tmr == 14'(`PWCD_SQ_CNT - 1)) begin
               d.tmr = 14'h0000;
               d.ind.red = ~q.ind.red; // see R15
               d.status = ~q.status; // see R17
            end
            if (err_low) begin
               d.status = 1'b0; // see R17
            end
            if (rise) begin
               d.taken = 1'b1;
            end
            if (!err_any) begin
               // Fault gone: resume outstanding fill runs or go ready
               d.ind.red = 1'b0;
               d.status = 1'b1;
               d.tmr = 14'h0000;
               d.taken = 1'b0;
               d.st = (q.runs != 6'h00) ? ST_GAP : ST_IDLE;
            end else if (fall && q.taken && is_ack && err_low) begin
               d.st = ST_ACK; // see R18
               d.chk = 1'b1;
               d.taken = 1'b0;
            end else if (fall) begin
               d.taken = 1'b0; // see R18
            end
         end

         // Self check after an acknowledge.
         // Outstanding fill runs are dropped: after an overload the
         // controller should decide afresh whether to dispense again.
         ST_ACK: begin
            d.status = 1'b0;
            d.chk = 1'b1;
            if (check_done_i) begin
               d.chk = 1'b0;
               d.st = ST_ERROR;
               d.tmr = 14'h0000;
               d.runs = 6'h00;
               if (check_pass_i) begin
                  d.ovl = fault_i.overload_fault; // see R18
                  d.uvl = fault_i.undervoltage_fault; // see R18
               end else begin
                  d.fatal = 1'b1;
               end
            end
         end

         default: begin
            d.st = ST_CHECK;
         end
      endcase
   end

   // State register; reset restarts in the self check
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.st <= ST_CHECK;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from flops
   assign status_o    = q.status;
   assign motor_run_o = q.motor;
   assign check_req_o = q.chk;
   assign ind_o       = q.ind;

endmodule

/* File: tb/pwcd_plc_model.sv */
/*
 Behavioural controller that drives command pulses onto the command line.
 Assumes the status line of the decoder and the bench clock; widths are in timebase ticks.
*/
`timescale 1ns/10ps
module pwcd_plc_model #(
   parameter int TICK_CYC    = 1,
   parameter int READY_TICKS = 3000,
   parameter int PAUSE_TICKS = 22000
) (
   input  wire logic clk_i,
   input  wire logic status_i,
   output logic      cmd_o
);
   int high_cnt;
   int idle_cnt;

   initial cmd_o = 1'h0;

   // Time the status high stretch and the quiet time since the last pulse
   always @(posedge clk_i) begin
      high_cnt <= status_i ? high_cnt + 1 : 0;
      idle_cnt <= cmd_o ? 0 : idle_cnt + 1;
   end

   // One high pulse of w ticks; early skips the waits so a scenario can break them
   task automatic send(input int w, input bit early);
      while (!early && (high_cnt <= READY_TICKS * TICK_CYC
             || idle_cnt < PAUSE_TICKS * TICK_CYC)) begin
         @(posedge clk_i);
      end
      @(posedge clk_i);
      #1 cmd_o = 1'h1;
      repeat (w * TICK_CYC) @(posedge clk_i);
      #1 cmd_o = 1'h0;
   endtask
endmodule

/* File: tb/pwcd_top_monitor.sv */
/*
 Concurrent checks on the ports of pwcd_top, attached by bind.
 Assumes one clock domain with the synchronous reset sys_rst_i.
*/
`timescale 1ns/10ps
module pwcd_top_monitor #(
   parameter int TICK_CYC = 1
) (
   input wire logic                  clk_i,
   input wire logic                  sys_rst_i,
   input wire logic                  cmd_pin_i,
   input wire logic                  motor_done_i,
   input wire logic [5:0]            pressure_i,
   input wire pwcd_pkg::pwcd_fault_t fault_i,
   input wire logic                  check_done_i,
   input wire logic                  check_pass_i,
   input wire logic                  status_o,
   input wire logic                  motor_run_o,
   input wire logic                  check_req_o,
   input wire pwcd_pkg::pwcd_ind_t   ind_o
);
   import pwcd_pkg::*;
   localparam int GAP_C = 500 * TICK_CYC;
   localparam int RDY_C = 3000 * TICK_CYC;
   int hi_q;

   // Length of the current high stretch on the status line
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hi_q <= 0;
      end else begin
         hi_q <= status_o ? hi_q + 1 : 0;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_run_low; motor_run_o |-> !status_o; endproperty
   a_run_low: assert property (p_run_low) else $error("status high in run");
   property p_green; motor_run_o |-> ind_o.green; endproperty
   a_green: assert property (p_green) else $error("green off in run");
   property p_press; motor_run_o [*2] |-> ind_o.pressure inside {[6'h01:6'h32]}; endproperty
   a_press: assert property (p_press) else $error("pressure out of range");
   // Synchroniser delay means the pin has been low a few cycles before any run
   property p_start; $rose(motor_run_o) |-> !cmd_pin_i && !$past(cmd_pin_i, 2); endproperty
   a_start: assert property (p_start) else $error("run began before pulse end");
   property p_done;
      motor_run_o && motor_done_i && fault_i == 5'h00 |=> status_o && !motor_run_o;
   endproperty
   a_done: assert property (p_done) else $error("status not high after run");
   // Gap tolerance of two cycles covers edge alignment of the timebase
   property p_gap;
      $rose(motor_run_o) |-> (hi_q >= GAP_C - 2 && hi_q <= GAP_C + 2) || hi_q > RDY_C;
   endproperty
   a_gap: assert property (p_gap) else $error("bad high time before run");
   property p_dash; $fell(ind_o.dash) |-> !motor_run_o [*8]; endproperty
   a_dash: assert property (p_dash) else $error("overlong pulse acted");
   property p_flash;
      ind_o.mode_flash |-> $past(cmd_pin_i, 4) || $past(cmd_pin_i, 5) || $past(cmd_pin_i, 6);
   endproperty
   a_flash: assert property (p_flash) else $error("mode flash without pulse");
   // Latched faults take one cycle to reach the sequencer, so the stop lands two edges later
   property p_fault; motor_run_o && |fault_i[3:0] |-> ##2 !motor_run_o && !status_o; endproperty
   a_fault: assert property (p_fault) else $error("run kept on fault");
endmodule

bind pwcd_top pwcd_top_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_pin_i(cmd_pin_i),
   .motor_done_i(motor_done_i), .pressure_i(pressure_i), .fault_i(fault_i),
   .check_done_i(check_done_i), .check_pass_i(check_pass_i), .status_o(status_o),
   .motor_run_o(motor_run_o), .check_req_o(check_req_o), .ind_o(ind_o)
);

/* File: tb/pwcd_top_tb.sv */
/*
 Self-checking bench for pwcd_top with a controller model on the command line.
 Assumes one clock per timebase tick; motor runs and self checks are short stand-ins.
*/
`timescale 1ns/10ps
module pwcd_top_tb;
   import pwcd_pkg::*;
   localparam int TC = 1;
   logic        clk_i, sys_rst_i, cmd_pin_i, motor_done_i, check_done_i, check_pass_i;
   logic [5:0]  pressure_i;
   pwcd_fault_t fault_i;
   logic        status_o, motor_run_o, check_req_o;
   pwcd_ind_t   ind_o;
   int          err_count, samples_checked, run_cnt, hi_len, gap_min, gap_max, chk_n, mot_n;
   bit          saw_flash, saw_dash, run_q;

   pwcd_top #(.TICK_CYC(TC)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_pin_i(cmd_pin_i),
      .motor_done_i(motor_done_i), .pressure_i(pressure_i), .fault_i(fault_i),
      .check_done_i(check_done_i), .check_pass_i(check_pass_i), .status_o(status_o),
      .motor_run_o(motor_run_o), .check_req_o(check_req_o), .ind_o(ind_o)
   );
   // Pause shortened: the decoder does not police it and the full figure would bloat the run
   pwcd_plc_model #(.TICK_CYC(TC), .PAUSE_TICKS(3000)) plc (
      .clk_i(clk_i), .status_i(status_o), .cmd_o(cmd_pin_i)
   );

   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end

   // Motor and self-check stand-ins plus run, gap and indication monitors
   always @(posedge clk_i) begin
      chk_n = check_req_o ? chk_n + 1 : 0;
      mot_n = motor_run_o ? mot_n + 1 : 0;
      if (motor_run_o && !run_q) begin
         run_cnt++;
         if (hi_len < 3000 * TC) begin
            gap_min = (hi_len < gap_min) ? hi_len : gap_min;
            gap_max = (hi_len > gap_max) ? hi_len : gap_max;
         end
      end
      hi_len = status_o ? hi_len + 1 : 0;
      run_q = motor_run_o;
      saw_flash |= ind_o.mode_flash;
      saw_dash |= ind_o.dash;
      #1;
      check_done_i = (chk_n == 20);
      motor_done_i = (mot_n == 100);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wait_hi(input int lim);
      for (int i = 0; i < lim && status_o !== 1'h1; i++) cyc(1);
   endtask

   task automatic t_single();
      wait_hi(500);
      chk(status_o, 1'h1, "ready after self check");
      chk(16'(run_cnt), 16'h0, "no run before command");
      plc.send(2000, 0);
      cyc(8);
      chk(motor_run_o, 1'h1, "run after pulse end");
      chk(status_o, 1'h0, "status low in run");
      chk(ind_o.green, 1'h1, "green in run");
      chk(saw_flash, 1'h1, "mode flash during pulse");
      cyc(50);
      chk(ind_o.pressure, 6'h32, "pressure clamped");
      cyc(60);
      chk(status_o, 1'h1, "status high after run");
      plc.send(2000, 1);
      cyc(20);
      chk(16'(run_cnt), 16'h1, "early pulse ignored");
      plc.send(2150, 0);
      cyc(20);
      chk(16'(run_cnt), 16'h1, "width off window ignored");
      plc.send(15200, 0);
      cyc(20);
      chk(saw_dash, 1'h1, "dash on overlong pulse");
      chk(16'(run_cnt), 16'h1, "overlong pulse ignored");
      $display("test single and refusals done");
   endtask

   task automatic t_fill();
      gap_min = 99999;
      gap_max = 0;
      plc.send(12000, 0);
      for (int i = 0; i < 40 * 700 && run_cnt != 41; i++) cyc(1);
      cyc(800);
      chk(16'(run_cnt), 16'h29, "forty runs then stop");
      chk(gap_min >= 499 && gap_max <= 501, 1'h1, "gap length");
      $display("test fill done");
   endtask

   task automatic t_fault();
      plc.send(2000, 0);
      cyc(30);
      fault_i.overload_fault = 1'h1;
      cyc(3);
      chk(motor_run_o, 1'h0, "run stopped by fault");
      chk(status_o, 1'h0, "status low on fault");
      fault_i.overload_fault = 1'h0;
      plc.send(2000, 1);
      cyc(20);
      chk(16'(run_cnt), 16'h2A, "stroke refused in error");
      chk(status_o, 1'h0, "fault held until acknowledge");
      plc.send(14000, 1);
      cyc(8);
      chk(check_req_o, 1'h1, "self check after acknowledge");
      wait_hi(200);
      chk(status_o, 1'h1, "acknowledge clears fault");
      $display("test fault done");
   endtask

   // Square wave starts low and flips every 1000 ticks after the run end
   task automatic t_empty();
      plc.send(2000, 0);
      cyc(30);
      fault_i.cart_empty = 1'h1;
      cyc(600);
      chk(status_o, 1'h0, "empty wave low half");
      cyc(1000);
      chk(status_o, 1'h1, "empty wave high half");
      chk(ind_o.red, 1'h1, "red flashes in error");
      fault_i = 5'h08;
      cyc(1000);
      chk(status_o, 1'h0, "missing cartridge holds low");
      fault_i = 5'h00;
      wait_hi(50);
      chk(status_o, 1'h1, "ready after new cartridge");
      $display("test empty done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      sys_rst_i = 1'h1;
      pressure_i = 6'h3C;
      fault_i = 5'h00;
      check_pass_i = 1'h1;
      motor_done_i = 1'h0;
      check_done_i = 1'h0;
      repeat (16) @(posedge clk_i);
      #1 sys_rst_i = 1'h0;
      t_single();
      t_fill();
      t_fault();
      t_empty();
      give_verdict();
   end

   // Watchdog sized a little above the expected length of all tests
   initial begin
      repeat (104000) @(posedge clk_i);
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
